// ===== design/pwm_defines.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  pulse-width-modulation submodule.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define PWM_OFS_COUNT       4'h0
`define PWM_OFS_PERIOD      4'h4
`define PWM_OFS_PULSE       4'h8
`define PWM_OFS_CTRL        4'hC

// ==========================================================================
// Control/status field positions
`define PWM_CTRL_PRE_LSB    0
`define PWM_CTRL_PRE_MSB    7
`define PWM_CTRL_SHARED_LSB 8
`define PWM_CTRL_SHARED_MSB 9
`define PWM_CTRL_EN_BIT     16
`define PWM_CTRL_TRANSPARENT_MODE_BIT_BIT   17
`define PWM_CTRL_POL_BIT    18
`define PWM_CTRL_DIR_BIT    19
`define PWM_CTRL_FF_BIT     24
`define PWM_CTRL_PIN_BIT    25

// ==========================================================================
// Reset values
`define PWM_RST_COUNT       16'h0000
`define PWM_RST_PERIOD      16'h0000
`define PWM_RST_PULSE       16'h0000
`define PWM_RST_PRE         8'h00
`define PWM_RST_SHARED      2'h0

// ==========================================================================
// Counter constants
`define PWM_CNT_ONE         16'h0001
`define PWM_CNT_ZERO        16'h0000
`define PWM_PRE_MAX         8'hFF

// Shared prescaler terminal counts (/2, /4, /8, /16)
`define PWM_SHARED_END2     4'h1
`define PWM_SHARED_END4     4'h3
`define PWM_SHARED_END8     4'h7
`define PWM_SHARED_END16    4'hF

// AXI responses
`define PWM_RESP_OKAY       2'h0
`define PWM_RESP_SLVERR     2'h2

`endif

// ===== design/pwm_pkg.sv
/*
  Types shared by the pulse-width-modulation submodule.
  Assumes the constants header is on the include path.
*/
package pwm_pkg;
  typedef logic [15:0] pwm_word_t;
  typedef logic [7:0]  pwm_pre_t;
  typedef logic [1:0]  pwm_resp_t;
endpackage

// ===== design/pwm_submodule.sv
/*
  Pulse-width-modulation submodule with AXI4-Lite register slave: shared
  prescaler, 8-bit own prescaler, 16-bit down-counter with period reload,
  double-buffered pulse width and an output flip-flop with polarity and
  direction control.
  Registers: count 0x0, period 0x4, pulse width 0x8, control 0xC; the
  control word holds preload [7:0], shared select [9:8], enable 16,
  transparent 17, polarity 18, direction 19, flip-flop 24 and pin 25.
  Assumes one 125 MHz clock, an asynchronous active-low reset and a master
  keeping AXI4-Lite handshake rules.
*/
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
// How it works
// - Own 8-bit prescaler after shared prescaler, 256 ratios
// - Enable edge loads prescaler preload into prescaler
// - Counter write also stores period register
// - Transparent mode: period write also loads counter
// - Enabled counter decrements at prescaler rate, readable
// - Count 0x0001 reloads period into counter
// - Buffered period reaches counter only at reload
// - Period 0x0000 gives 65536-count free run
// - Period 0x0001 matches every count, never below
// - Period 0x0002 toggles two, one, reload
// - Pulse width held visible plus hidden buffer
// - Transparent mode copies pulse width into buffer
// - Disabled: pulse width write also updates buffer
// - Buffered pulse width moves at count 0x0001
// - Set at width match, reset at 0x0001
// - Visible pulse width untouched by hardware
// - Width from one count to period minus one
// - Pin buffer with polarity and direction control
`timescale 1ns/1ps
`include "pwm_defines.svh"

module pwm_submodule (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [3:0]       s_axi_awaddr_i,
  input  wire logic             s_axi_awvalid_i,
  output logic                  s_axi_awready_o,
  input  wire logic [31:0]      s_axi_wdata_i,
  input  wire logic [3:0]       s_axi_wstrb_i,
  input  wire logic             s_axi_wvalid_i,
  output logic                  s_axi_wready_o,
  output pwm_pkg::pwm_resp_t    s_axi_bresp_o,
  output logic                  s_axi_bvalid_o,
  input  wire logic             s_axi_bready_i,
  input  wire logic [3:0]       s_axi_araddr_i,
  input  wire logic             s_axi_arvalid_i,
  output logic                  s_axi_arready_o,
  output logic [31:0]           s_axi_rdata_o,
  output pwm_pkg::pwm_resp_t    s_axi_rresp_o,
  output logic                  s_axi_rvalid_o,
  input  wire logic             s_axi_rready_i,
  input  wire logic             pwm_pin_i,
  output logic                  pwm_pin_o,
  output logic                  pwm_pin_oe_o
);
  import pwm_pkg::*;

  // ========================================================================
  // State
  logic             aw_held_ff, nxt_aw_held;
  logic             w_held_ff, nxt_w_held;
  logic [3:0]       awaddr_ff, nxt_awaddr;
  logic [31:0]      wdata_ff, nxt_wdata;
  logic [3:0]       wstrb_ff, nxt_wstrb;
  logic             bvalid_ff, nxt_bvalid;
  pwm_resp_t        bresp_ff, nxt_bresp;
  logic             rvalid_ff, nxt_rvalid;
  pwm_resp_t        rresp_ff, nxt_rresp;
  logic [31:0]      rdata_ff, nxt_rdata;

  pwm_word_t        count_ff, nxt_count;
  pwm_word_t        period_ff, nxt_period;
  pwm_word_t        pulse_vis_ff, nxt_pulse_vis;
  pwm_word_t        pulse_buf_ff, nxt_pulse_buf;
  pwm_pre_t         pre_load_ff, nxt_pre_load;
  logic [1:0]       shared_sel_ff, nxt_shared_sel;
  logic             enable_ff, nxt_enable;
  logic             transparent_mode_bit_ff, nxt_transparent_mode_bit;
  logic             pol_ff, nxt_pol;
  logic             dir_ff, nxt_dir;
  logic [3:0]       shared_cnt_ff, nxt_shared_cnt;
  pwm_pre_t         pre_cnt_ff, nxt_pre_cnt;
  logic             out_ff, nxt_out;
  logic             pin_o_ff, nxt_pin_o;
  logic             pin_oe_ff, nxt_pin_oe;

  logic             wr_fire;
  logic             rd_fire;
  logic             shared_tick;
  logic             pwm_tick;
  logic             wr_count;
  logic             wr_period;
  logic             wr_pulse;
  logic             wr_ctrl;
  logic [3:0]       shared_div;
  pwm_word_t        wr_half;
  logic [31:0]      ctrl_word;
  logic             nxt_awready;
  logic             nxt_wready;
  logic             nxt_arready;

  // ========================================================================
  // AXI4-Lite write and read channels
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_half = {wstrb_ff[1] ? wdata_ff[15:8] : 8'h00, wdata_ff[7:0]};
  assign wr_count  = wr_fire && (awaddr_ff == `PWM_OFS_COUNT);
  assign wr_period = wr_fire && (awaddr_ff == `PWM_OFS_PERIOD);
  assign wr_pulse  = wr_fire && (awaddr_ff == `PWM_OFS_PULSE);
  assign wr_ctrl   = wr_fire && (awaddr_ff == `PWM_OFS_CTRL);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`PWM_CTRL_PRE_MSB:`PWM_CTRL_PRE_LSB]       = pre_load_ff;
    ctrl_word[`PWM_CTRL_SHARED_MSB:`PWM_CTRL_SHARED_LSB] = shared_sel_ff;
    ctrl_word[`PWM_CTRL_EN_BIT]   = enable_ff;
    ctrl_word[`PWM_CTRL_TRANSPARENT_MODE_BIT_BIT] = transparent_mode_bit_ff;
    ctrl_word[`PWM_CTRL_POL_BIT]  = pol_ff;
    ctrl_word[`PWM_CTRL_DIR_BIT]  = dir_ff;
    ctrl_word[`PWM_CTRL_FF_BIT]   = out_ff;
    ctrl_word[`PWM_CTRL_PIN_BIT]  = pwm_pin_i;
  end

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_held  = w_held_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata_i;
      nxt_wstrb  = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      // Unaligned address: error response, no register touched
      nxt_bresp   = (awaddr_ff[1:0] == 2'h0) ? `PWM_RESP_OKAY : `PWM_RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `PWM_RESP_OKAY;
      case (s_axi_araddr_i)
        `PWM_OFS_COUNT:  nxt_rdata = {16'h0000, count_ff};
        `PWM_OFS_PERIOD: nxt_rdata = {16'h0000, period_ff};
        `PWM_OFS_PULSE:  nxt_rdata = {16'h0000, pulse_vis_ff};
        `PWM_OFS_CTRL:   nxt_rdata = ctrl_word;
        // Unmapped read: zero data with error response
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = `PWM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  // ========================================================================
  // Ready generation
  // No new beat while a slot is held or the response waits
  always_comb begin
    nxt_awready = !nxt_aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
    nxt_wready  = !nxt_w_held && !(s_axi_wvalid_i && s_axi_wready_o);
    nxt_arready = !nxt_rvalid && !rd_fire;
    if (nxt_bvalid || bvalid_ff) begin
      nxt_awready = 1'b0;
      nxt_wready  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 4'h0;
      w_held_ff  <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `PWM_RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `PWM_RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff  <= nxt_awaddr;
      w_held_ff  <= nxt_w_held;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      s_axi_awready_o <= nxt_awready;
      s_axi_wready_o  <= nxt_wready;
      s_axi_arready_o <= nxt_arready;
    end
  end

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o  = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o  = rresp_ff;
  assign s_axi_rdata_o  = rdata_ff;

  // ========================================================================
  // Control register
  always_comb begin
    nxt_pre_load   = pre_load_ff;
    nxt_shared_sel = shared_sel_ff;
    nxt_enable     = enable_ff;
    nxt_transparent_mode_bit       = transparent_mode_bit_ff;
    nxt_pol        = pol_ff;
    nxt_dir        = dir_ff;
    if (wr_ctrl) begin
      if (wstrb_ff[0]) begin
        nxt_pre_load = wdata_ff[`PWM_CTRL_PRE_MSB:`PWM_CTRL_PRE_LSB];
      end
      if (wstrb_ff[1]) begin
        nxt_shared_sel = wdata_ff[`PWM_CTRL_SHARED_MSB:`PWM_CTRL_SHARED_LSB];
      end
      if (wstrb_ff[2]) begin
        nxt_enable = wdata_ff[`PWM_CTRL_EN_BIT];
        nxt_transparent_mode_bit   = wdata_ff[`PWM_CTRL_TRANSPARENT_MODE_BIT_BIT];
        nxt_pol    = wdata_ff[`PWM_CTRL_POL_BIT];
        nxt_dir    = wdata_ff[`PWM_CTRL_DIR_BIT];
      end
    end
  end

  // ========================================================================
  // Prescalers: shared /2,/4,/8,/16 then own 256-ratio divider
  always_comb begin
    case (shared_sel_ff)
      2'h0:    shared_div = `PWM_SHARED_END2;
      2'h1:    shared_div = `PWM_SHARED_END4;
      2'h2:    shared_div = `PWM_SHARED_END8;
      default: shared_div = `PWM_SHARED_END16;
    endcase
  end

  // Shared divider runs free; own divider holds while disabled
  // Counter ticks only while enabled
  assign shared_tick = (shared_cnt_ff == shared_div);
  assign pwm_tick    = enable_ff && shared_tick && (pre_cnt_ff == `PWM_PRE_MAX);

  always_comb begin
    nxt_shared_cnt = shared_tick ? 4'h0 : shared_cnt_ff + 4'h1;
    nxt_pre_cnt    = pre_cnt_ff;
    if (nxt_enable && !enable_ff) begin
      nxt_pre_cnt = nxt_pre_load;
    end else if (enable_ff && shared_tick) begin
      if (pre_cnt_ff == `PWM_PRE_MAX) begin
        nxt_pre_cnt = pre_load_ff;
      end else begin
        nxt_pre_cnt = pre_cnt_ff + 8'h01;
      end
    end
  end

  // ========================================================================
  // Down-counter, period and pulse width
  always_comb begin
    nxt_count     = count_ff;
    nxt_period    = period_ff;
    nxt_pulse_vis = pulse_vis_ff;
    nxt_pulse_buf = pulse_buf_ff;
    nxt_out       = out_ff;
    if (pwm_tick) begin
      if (count_ff == `PWM_CNT_ONE) begin
        nxt_count     = period_ff;
        nxt_pulse_buf = pulse_vis_ff;
        nxt_out       = 1'b0;
      end else begin
        nxt_count = count_ff - 16'h0001;
      end
      // Width match sets, 0x0001 resets; period one keeps output set unless width is zero
      // Compare against the width that belongs to the reloaded period
      if (nxt_count == nxt_pulse_buf && nxt_pulse_buf != `PWM_CNT_ZERO) begin
        nxt_out = 1'b1;
      end
      if (period_ff == `PWM_CNT_ONE) begin
        nxt_out = (nxt_pulse_buf != `PWM_CNT_ZERO);
      end
    end
    // Software write in the tick cycle wins over counting
    if (wr_count) begin
      nxt_count  = wr_half;
      nxt_period = wr_half;
    end
    if (wr_period) begin
      nxt_period = wr_half;
      if (transparent_mode_bit_ff) begin
        nxt_count = wr_half;
      end
    end
    if (wr_pulse) begin
      nxt_pulse_vis = wr_half;
      if (transparent_mode_bit_ff || !enable_ff) begin
        nxt_pulse_buf = wr_half;
      end
    end
  end

  // Pin buffer with polarity and direction
  // Registered beside the flip-flop so the pin cannot glitch
  always_comb begin
    nxt_pin_o  = nxt_out ^ nxt_pol;
    nxt_pin_oe = nxt_dir;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_load_ff   <= `PWM_RST_PRE;
      shared_sel_ff <= `PWM_RST_SHARED;
      enable_ff     <= 1'b0;
      transparent_mode_bit_ff       <= 1'b0;
      pol_ff        <= 1'b0;
      dir_ff        <= 1'b0;
      shared_cnt_ff <= 4'h0;
      pre_cnt_ff    <= `PWM_RST_PRE;
      count_ff      <= `PWM_RST_COUNT;
      period_ff     <= `PWM_RST_PERIOD;
      pulse_vis_ff  <= `PWM_RST_PULSE;
      pulse_buf_ff  <= `PWM_RST_PULSE;
      out_ff        <= 1'b0;
      pin_o_ff      <= 1'b0;
      pin_oe_ff     <= 1'b0;
    end else begin
      pre_load_ff   <= nxt_pre_load;
      shared_sel_ff <= nxt_shared_sel;
      enable_ff     <= nxt_enable;
      transparent_mode_bit_ff       <= nxt_transparent_mode_bit;
      pol_ff        <= nxt_pol;
      dir_ff        <= nxt_dir;
      shared_cnt_ff <= nxt_shared_cnt;
      pre_cnt_ff    <= nxt_pre_cnt;
      count_ff      <= nxt_count;
      period_ff     <= nxt_period;
      pulse_vis_ff  <= nxt_pulse_vis;
      pulse_buf_ff  <= nxt_pulse_buf;
      out_ff        <= nxt_out;
      pin_o_ff      <= nxt_pin_o;
      pin_oe_ff     <= nxt_pin_oe;
    end
  end

  assign pwm_pin_o    = pin_o_ff;
  assign pwm_pin_oe_o = pin_oe_ff;

endmodule

// ===== testbench/pwm_submodule_properties.sv
/*
  Checker of the PWM submodule bus handshakes and pin after reset.
  Assumes binding onto pwm_submodule, one clock, active-low reset.
*/
`timescale 1ns/1ps
module pwm_props (
  input wire logic               core_clk_i,
  input wire logic               rstn_i,
  input wire logic [3:0]         s_axi_awaddr_i,
  input wire logic               s_axi_awvalid_i,
  input wire logic               s_axi_awready_o,
  input wire logic               s_axi_wvalid_i,
  input wire logic               s_axi_wready_o,
  input wire pwm_pkg::pwm_resp_t s_axi_bresp_o,
  input wire logic               s_axi_bvalid_o,
  input wire logic               s_axi_bready_i,
  input wire logic [3:0]         s_axi_araddr_i,
  input wire logic               s_axi_arvalid_i,
  input wire logic               s_axi_arready_o,
  input wire logic [31:0]        s_axi_rdata_o,
  input wire pwm_pkg::pwm_resp_t s_axi_rresp_o,
  input wire logic               s_axi_rvalid_o,
  input wire logic               s_axi_rready_i,
  input wire logic               pwm_pin_o,
  input wire logic               pwm_pin_oe_o
);
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================================
  // Assertions
  AST_RST_QUIET: assert property ($rose(rstn_i) |-> !pwm_pin_o && !pwm_pin_oe_o)
    else $error("pin active right after reset");
  AST_B_LAT: assert property (wr_go |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  AST_B_ONCE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  AST_AW_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  AST_WR_ERR: assert property (wr_go && s_axi_awaddr_i[1:0] != 2'h0 |-> ##2 s_axi_bresp_o == 2'h2)
    else $error("unaligned write not refused");
  AST_R_LAT: assert property (rd_go |=> s_axi_rvalid_o)
    else $error("read data late");
  AST_R_ONCE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read data repeated");
  AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
  AST_RD_ERR: assert property (rd_go && s_axi_araddr_i[1:0] != 2'h0 |=> s_axi_rresp_o == 2'h2)
    else $error("unaligned read not refused");
  AST_RD_UPPER: assert property (rd_go && s_axi_araddr_i != 4'hC |=> s_axi_rdata_o[31:16] == 16'h0)
    else $error("upper half of narrow register not zero");
  COV_WR: cover property (wr_go);
  COV_RD: cover property (rd_go);
  COV_PIN: cover property ($rose(pwm_pin_o));
endmodule

bind pwm_submodule pwm_props pwm_props_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o)
);

// ===== testbench/pwm_far_end.sv
/*
  Circuit on the PWM pin: measures period and high time in clocks.
  Assumes the bench clock; shows the inverse of the pin when not driven.
*/
`timescale 1ns/1ps
module pwm_far_end (
  input  wire logic        core_clk_i,
  input  wire logic        drive_i,
  input  wire logic        oe_i,
  output logic             level_o,
  output logic [31:0]      per_len_o,
  output logic [31:0]      hi_len_o,
  output logic [31:0]      rises_o
);
  logic [31:0] cyc_ff  = 32'h0;
  logic [31:0] rise_ff = 32'h0;
  logic [31:0] per_ff  = 32'h0;
  logic [31:0] hi_ff   = 32'h0;
  logic [31:0] cnt_ff  = 32'h0;
  logic        last_ff = 1'h0;
  // ==========================================================================
  // Pin level and edge timing
  assign level_o   = oe_i ? drive_i : ~drive_i;
  assign per_len_o = per_ff;
  assign hi_len_o  = hi_ff;
  assign rises_o   = cnt_ff;
  always @(posedge core_clk_i) begin
    cyc_ff  <= cyc_ff + 32'h1;
    last_ff <= drive_i;
    if (drive_i && !last_ff) begin
      per_ff  <= cyc_ff - rise_ff;
      rise_ff <= cyc_ff;
      cnt_ff  <= cnt_ff + 32'h1;
    end
    if (!drive_i && last_ff) begin
      hi_ff <= cyc_ff - rise_ff;
    end
  end
endmodule

// ===== testbench/pwm_submodule_test.sv
/*
  Self-checking bench of the PWM submodule over its register bus.
  Assumes the far-end model on the pin and the bound checker.
*/
`timescale 1ns/1ps
module pwm_submodule_test;
  import pwm_pkg::*;
  logic        core_clk_i = 1'h0;
  logic        rstn_i     = 1'h0;
  logic [3:0]  awaddr     = 4'h0;
  logic [3:0]  araddr     = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic        awvalid    = 1'h0;
  logic        wvalid     = 1'h0;
  logic        arvalid    = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin_lvl;
  logic [31:0] rdata, per_len, hi_len, rises, seed, v, w;
  logic [15:0] p;
  pwm_resp_t   bresp, rresp, resp;
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  always #4 core_clk_i = ~core_clk_i;

  pwm_submodule pwm_submodule_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'h1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'h1), .pwm_pin_i(pin_lvl), .pwm_pin_o(pin_o), .pwm_pin_oe_o(pin_oe));
  pwm_far_end pwm_far_end_inst (
    .core_clk_i(core_clk_i), .drive_i(pin_o), .oe_i(pin_oe), .level_o(pin_lvl),
    .per_len_o(per_len), .hi_len_o(hi_len), .rises_o(rises));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctl(input logic [7:0] pre, input logic [1:0] sel,
                                      input logic en, tr, pol, dir);
    return {12'h000, dir, pol, tr, en, 6'h00, sel, pre};
  endfunction
  function automatic logic [31:0] tick(input logic [7:0] pre, input logic [1:0] sel);
    return (32'h100 - {24'h0, pre}) << ({1'b0, sel} + 3'h1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk_i);
      if (awvalid && awready) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge core_clk_i); while (bvalid !== 1'h1);
    resp = bresp;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge core_clk_i); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge core_clk_i); while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
  endtask
  task automatic setup(input logic [15:0] per, pul, input logic [7:0] pre,
                       input logic [1:0] sel, input logic tr, pol);
    wr(4'hC, ctl(pre, sel, 1'h0, tr, pol, 1'h1));
    wr(4'h0, {16'h0, per});
    wr(4'h8, {16'h0, pul});
    wr(4'hC, ctl(pre, sel, 1'h1, tr, pol, 1'h1));
  endtask
  task automatic meas(input logic [15:0] per, pul, input logic [7:0] pre,
                      input logic [1:0] sel, input logic tr);
    setup(per, pul, pre, sel, tr, 1'h0);
    w = rises;
    wait (rises == w + 32'h3);
    @(posedge core_clk_i);
    chk(per_len, per * tick(pre, sel));
    chk(hi_len, pul * tick(pre, sel));
    rd(4'h8, v);
    chk(v, {16'h0, pul});
    $display("period %h width %h done", per, pul);
  endtask
  task automatic hold_chk(input logic exp);
    repeat (8) @(posedge core_clk_i);
    repeat (16) begin
      @(posedge core_clk_i);
      chk({31'h0, pin_o}, {31'h0, exp});
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_mismatch++;
    stop_test();
  end
  initial begin
    seed = 32'hD61B;
    repeat (20) @(posedge core_clk_i);
    rstn_i <= 1'h1;
    @(posedge core_clk_i);
    for (int i = 0; i < 4; i++) begin
      rd({i[1:0], 2'h0}, v);
      chk(v, (i == 3) ? 32'h0200_0000 : 32'h0);
    end
    rd(4'h2, v);
    chk({30'h0, resp}, 32'h2);
    wr(4'h6, 32'h1);
    chk({30'h0, resp}, 32'h2);
    wr(4'h0, 32'h1234);
    rd(4'h4, v);
    chk(v, 32'h1234);
    $display("reset and access test done");
    meas(16'h2, 16'h1, 8'hFF, 2'h0, 1'h0);
    meas(16'h5, 16'h4, 8'hFE, 2'h3, 1'h1);
    meas(16'h6, 16'h2, 8'hFF, 2'h0, 1'h0);
    wr(4'h4, 32'hA);
    rd(4'h0, v);
    chk({31'h0, v <= 32'h6}, 32'h1);
    w = rises;
    wait (rises == w + 32'h3);
    @(posedge core_clk_i);
    chk(per_len, 32'hA * tick(8'hFF, 2'h0));
    wr(4'hC, ctl(8'hFF, 2'h0, 1'h1, 1'h1, 1'h0, 1'h1));
    wr(4'h4, 32'h3000);
    rd(4'h0, v);
    rd(4'h0, w);
    chk({31'h0, v > 32'h2F00 && v <= 32'h3000}, 32'h1);
    chk({31'h0, w < v}, 32'h1);
    setup(16'h0, 16'h1, 8'hFF, 2'h0, 1'h0, 1'h0);
    repeat (12) @(posedge core_clk_i);
    rd(4'h0, v);
    chk({31'h0, v > 32'hFF00}, 32'h1);
    $display("counter load test done");
    setup(16'h1, 16'h1, 8'hFF, 2'h0, 1'h0, 1'h0);
    hold_chk(1'h1);
    rd(4'hC, v);
    chk(v, ctl(8'hFF, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1) | 32'h0300_0000);
    setup(16'h1, 16'h0, 8'hFF, 2'h0, 1'h0, 1'h0);
    hold_chk(1'h0);
    setup(16'h1, 16'h0, 8'hFF, 2'h0, 1'h0, 1'h1);
    hold_chk(1'h1);
    wr(4'hC, ctl(8'hFF, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0));
    @(posedge core_clk_i);
    chk({31'h0, pin_oe}, 32'h0);
    $display("pin test done");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      p = 16'h3 + {12'h0, seed[3:0]};
      meas(p, 16'h1 + ({12'h0, seed[7:4]} % (p - 16'h1)), 8'hF8 | {5'h0, seed[10:8]},
           seed[12:11], seed[13]);
    end
    stop_test();
  end
endmodule
